// ===== hdl/mier_consts.vh
/*
 * register offsets, field positions, reset values and masks of the maskable
 * interrupt enable block.
 * assumes: included by bare name from files under hdl/.
 */
`ifndef MIER_CONSTS_VH
`define MIER_CONSTS_VH

`define MIER_OFF_EN_LOW 12'h000
`define MIER_OFF_EN_HIGH 12'h004
`define MIER_OFF_PEND_LOW 12'h008
`define MIER_OFF_PEND_HIGH 12'h00c
`define MIER_OFF_CTRL 12'h010
`define MIER_OFF_SVC_LOW 12'h014
`define MIER_OFF_SVC_HIGH 12'h018
`define MIER_OFF_IRQ_STAT 12'h01c
`define MIER_OFF_IRQ_MASK 12'h020

`define MIER_EN_LOW_RST 16'h0000
`define MIER_EN_HIGH_RST 16'h0000
`define MIER_EN_LOW_WMASK 16'hfffc
`define MIER_EN_HIGH_WMASK 16'h07ff
`define MIER_POS_OS 10
`define MIER_POS_LOG 9
`define MIER_POS_BUSERR 8
`define MIER_CTRL_GMASK_POS 0
`define MIER_CTRL_RST 1'h1
`define MIER_IRQ_W 2
`define MIER_IRQ_POS_PEND 0
`define MIER_IRQ_POS_SVC 1
`define MIER_RESP_OKAY 2'h0
`define MIER_RESP_SLVERR 2'h2

`endif

// ===== hdl/mier_pend.v
/*
 * pending flags for one 16-bit half: set by requests, cleared by write-one.
 * assumes: request pulses synchronous to sys_clk; reserved bits held at zero.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mier_consts.vh"

module mier_pend (
    input wire sys_clk,
    input wire rst_n,
    input wire [15:0] req,
    input wire [15:0] clr,
    input wire [15:0] valid_mask,
    output reg [15:0] flags_q
);
    wire [15:0] flags_d;

    // set regardless of enable; a set beats a same-cycle clear
    assign flags_d = ((flags_q & ~clr) | req) & valid_mask;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= 16'h0000;
        end else begin
            flags_q <= flags_d;
        end
    end
endmodule

`default_nettype wire

// ===== hdl/mier_gate.v
/*
 * combines pending flags, enables and the global mask into service requests.
 * assumes: all inputs come from flip-flops in the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module mier_gate (
    input wire [15:0] pend_low,
    input wire [15:0] pend_high,
    input wire [15:0] en_low,
    input wire [15:0] en_high,
    input wire global_irq_mask,
    output wire [15:0] svc_low,
    output wire [15:0] svc_high,
    output wire any_svc
);
    assign svc_low = global_irq_mask ? 16'h0000 : (pend_low & en_low);
    assign svc_high = global_irq_mask ? 16'h0000 : (pend_high & en_high);
    assign any_svc = |{svc_low, svc_high};
endmodule

`default_nettype wire

// ===== hdl/mier_top.v
/*
 * maskable interrupt enable registers with pending flags, global mask and an
 * axi4-lite register slave; service requests and an interrupt line go out.
 * assumes: one clock, sys_clk at 40 mhz; request inputs are one-cycle pulses
 * or levels synchronous to sys_clk; the software reset instruction arrives as
 * a pulse on sw_reset.
 */
// Notes on behaviour
// - writing one enables that interrupt
// - writing zero disables, blocking service
// - hardware reset clears both enable masks
// - software reset leaves enable masks alone
// - high mask bits 15..11 read zero
// - high bit 10 enables os interrupt
// - high bit 9 enables log interrupt
// - high bit 8 enables bus-error interrupt
// - high bits 0..7 enable vectors 16..23
// - low bits 2..15 enable vectors; 1..0 zero
// - requests set pending flags regardless enables
`timescale 1ns/1ps
`default_nettype none
`include "mier_consts.vh"

module mier_top (
    input wire sys_clk,
    input wire rst_n,
    input wire sw_reset,
    input wire [15:0] vec_req_low,
    input wire [7:0] vec_req_high,
    input wire os_irq,
    input wire log_irq,
    input wire buserr_irq,
    input wire [15:0] ack_low,
    input wire [15:0] ack_high,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [15:0] svc_low_q,
    output reg [15:0] svc_high_q,
    output reg global_irq_mask_q,
    output reg irq_q
);
    reg [15:0] irq_enable_low_q;
    reg [15:0] irq_enable_high_q;
    reg [`MIER_IRQ_W-1:0] irq_stat_q;
    reg [`MIER_IRQ_W-1:0] irq_mask_q;
    reg [11:0] aw_addr_q;
    reg aw_have_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg w_have_q;
    reg [31:0] pend_rise_q;
    reg svc_prev_q;

    wire [15:0] pend_low;
    wire [15:0] pend_high;
    wire [15:0] svc_low;
    wire [15:0] svc_high;
    wire any_svc;
    wire wr_fire;
    wire [15:0] clr_low;
    wire [15:0] clr_high;
    wire [15:0] req_high;
    wire [`MIER_IRQ_W-1:0] irq_ev;
    wire [`MIER_IRQ_W-1:0] irq_stat_d;
    reg [31:0] rd_word;
    reg rd_hit;

    // merges the write strobes of the low half-word into old contents
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        input [15:0] wmask;
        reg [15:0] nv;
        begin
            nv = old;
            if (strb[0]) begin
                nv[7:0] = data[7:0];
            end
            if (strb[1]) begin
                nv[15:8] = data[15:8];
            end
            merge16 = nv & wmask;
        end
    endfunction

    function hit;
        input [11:0] a;
        input [11:0] off;
        begin
            hit = (a[11:2] == off[11:2]);
        end
    endfunction

    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

    // vectors 16..23 sit in the low byte
    assign req_high = {5'h00, os_irq, log_irq, buserr_irq, vec_req_high};

    assign clr_low = ack_low | ((wr_fire && hit(aw_addr_q, `MIER_OFF_PEND_LOW) && w_strb_q[1:0] == 2'h3) ?
        w_data_q[15:0] : 16'h0000);
    assign clr_high = ack_high | ((wr_fire && hit(aw_addr_q, `MIER_OFF_PEND_HIGH) && w_strb_q[1:0] == 2'h3) ?
        w_data_q[15:0] : 16'h0000);

    mier_pend u_pend_low (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .req(vec_req_low),
        .clr(clr_low),
        .valid_mask(`MIER_EN_LOW_WMASK),
        .flags_q(pend_low)
    );

    mier_pend u_pend_high (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .req(req_high),
        .clr(clr_high),
        .valid_mask(`MIER_EN_HIGH_WMASK),
        .flags_q(pend_high)
    );

    mier_gate u_gate (
        .pend_low(pend_low),
        .pend_high(pend_high),
        .en_low(irq_enable_low_q),
        .en_high(irq_enable_high_q),
        .global_irq_mask(global_irq_mask_q),
        .svc_low(svc_low),
        .svc_high(svc_high),
        .any_svc(any_svc)
    );

    // sw_reset deliberately does not touch the enables
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable_low_q <= `MIER_EN_LOW_RST;
            irq_enable_high_q <= `MIER_EN_HIGH_RST;
            global_irq_mask_q <= `MIER_CTRL_RST;
        end else begin
            if (sw_reset) begin
                // software reset masks globally but keeps the enables
                global_irq_mask_q <= `MIER_CTRL_RST;
            end else if (wr_fire && hit(aw_addr_q, `MIER_OFF_CTRL) && w_strb_q[0]) begin
                // software unmasks after loading the enables
                global_irq_mask_q <= w_data_q[`MIER_CTRL_GMASK_POS];
            end
            // bits 1..0 of the low mask stay zero
            if (wr_fire && hit(aw_addr_q, `MIER_OFF_EN_LOW)) begin
                irq_enable_low_q <= merge16(irq_enable_low_q, w_data_q, w_strb_q, `MIER_EN_LOW_WMASK);
            end
            // bits 10, 9, 8 are plain r/w
            if (wr_fire && hit(aw_addr_q, `MIER_OFF_EN_HIGH)) begin
                irq_enable_high_q <= merge16(irq_enable_high_q, w_data_q, w_strb_q, `MIER_EN_HIGH_WMASK);
            end
        end
    end

    // events: a new pending flag, and service becoming available
    // both halves kept apart so a new flag is seen even when its twin is set
    assign irq_ev[`MIER_IRQ_POS_PEND] = |({pend_high, pend_low} & ~pend_rise_q);
    assign irq_ev[`MIER_IRQ_POS_SVC] = any_svc && !svc_prev_q;
    // a write-one clear loses to an event in the same cycle
    assign irq_stat_d = (irq_stat_q & ~((wr_fire && hit(aw_addr_q, `MIER_OFF_IRQ_STAT) && w_strb_q[0]) ?
        w_data_q[`MIER_IRQ_W-1:0] : {`MIER_IRQ_W{1'b0}})) | irq_ev;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= {`MIER_IRQ_W{1'b0}};
            irq_mask_q <= {`MIER_IRQ_W{1'b0}};
            irq_q <= 1'b0;
            pend_rise_q <= 32'h00000000;
            svc_prev_q <= 1'b0;
            svc_low_q <= 16'h0000;
            svc_high_q <= 16'h0000;
        end else begin
            irq_stat_q <= irq_stat_d;
            if (wr_fire && hit(aw_addr_q, `MIER_OFF_IRQ_MASK) && w_strb_q[0]) begin
                irq_mask_q <= w_data_q[`MIER_IRQ_W-1:0];
            end
            irq_q <= |(irq_stat_q & irq_mask_q);
            pend_rise_q <= {pend_high, pend_low};
            svc_prev_q <= any_svc;
            svc_low_q <= svc_low;
            svc_high_q <= svc_high;
        end
    end

    // write channel: address and data taken in either order
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_addr_q <= 12'h000;
            aw_have_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            w_have_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MIER_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known(aw_addr_q) ? `MIER_RESP_OKAY : `MIER_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function wr_known;
        input [11:0] a;
        begin
            wr_known = hit(a, `MIER_OFF_EN_LOW) || hit(a, `MIER_OFF_EN_HIGH) ||
                hit(a, `MIER_OFF_PEND_LOW) || hit(a, `MIER_OFF_PEND_HIGH) ||
                hit(a, `MIER_OFF_CTRL) || hit(a, `MIER_OFF_SVC_LOW) ||
                hit(a, `MIER_OFF_SVC_HIGH) || hit(a, `MIER_OFF_IRQ_STAT) ||
                hit(a, `MIER_OFF_IRQ_MASK);
        end
    endfunction

    // read mux; upper 16 bits and reserved bits read zero
    always @* begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        if (hit(s_axi_araddr, `MIER_OFF_EN_LOW)) begin
            rd_word[15:0] = irq_enable_low_q;
        end else if (hit(s_axi_araddr, `MIER_OFF_EN_HIGH)) begin
            rd_word[15:0] = irq_enable_high_q & `MIER_EN_HIGH_WMASK;
        end else if (hit(s_axi_araddr, `MIER_OFF_PEND_LOW)) begin
            rd_word[15:0] = pend_low;
        end else if (hit(s_axi_araddr, `MIER_OFF_PEND_HIGH)) begin
            rd_word[15:0] = pend_high;
        end else if (hit(s_axi_araddr, `MIER_OFF_CTRL)) begin
            rd_word[`MIER_CTRL_GMASK_POS] = global_irq_mask_q;
        end else if (hit(s_axi_araddr, `MIER_OFF_SVC_LOW)) begin
            rd_word[15:0] = svc_low;
        end else if (hit(s_axi_araddr, `MIER_OFF_SVC_HIGH)) begin
            rd_word[15:0] = svc_high;
        end else if (hit(s_axi_araddr, `MIER_OFF_IRQ_STAT)) begin
            rd_word[`MIER_IRQ_W-1:0] = irq_stat_q;
        end else if (hit(s_axi_araddr, `MIER_OFF_IRQ_MASK)) begin
            rd_word[`MIER_IRQ_W-1:0] = irq_mask_q;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `MIER_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `MIER_RESP_OKAY : `MIER_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// ===== testbench/mier_monitor.sv
/* port assertions for the interrupt enable block.
   assumes: bound to mier_top, single sys_clk domain. */
`timescale 1ns/1ps
`default_nettype none
module mier_chk (
    input wire sys_clk,
    input wire rst_n,
    input wire sw_reset,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [15:0] svc_low_q,
    input wire [15:0] svc_high_q,
    input wire global_irq_mask_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence ar_hit;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence w_hit;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    low_rsvd_a: assert property (svc_low_q[1:0] == 2'h0) else $error("svc low reserved");
    high_rsvd_a: assert property (svc_high_q[15:11] == 5'h00) else $error("svc high reserved");
    masked_svc_a: assert property (|{svc_low_q, svc_high_q} |-> !$past(global_irq_mask_q))
        else $error("service while masked");
    swr_mask_a: assert property (sw_reset |=> global_irq_mask_q) else $error("sw reset mask");
    rd_resp_a: assert property (ar_hit |=> s_axi_rvalid) else $error("read late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper bits");
    // word index compare: byte lanes 1..3 of the last register are still mapped
    unmap_rd_a: assert property (ar_hit ##0 s_axi_araddr[11:2] > 10'h008 |=> s_axi_rresp == 2'h2
        && s_axi_rdata == 32'h0) else $error("unmapped read");
    wr_resp_a: assert property (w_hit |-> ##[1:3] s_axi_bvalid) else $error("write late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write resp dropped");
endmodule
bind mier_top mier_chk chk_u (.sys_clk, .rst_n, .sw_reset, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .svc_low_q,
    .svc_high_q, .global_irq_mask_q);
`default_nettype wire

// ===== testbench/mier_src.sv
/* request sources and dispatch side of the enable block.
   assumes: bit b of a 32-bit index maps low half 0..15, high half 16..31. */
`timescale 1ns/1ps
`default_nettype none
module mier_src (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ack_en,
    input wire logic [15:0] svc_low_q,
    input wire logic [15:0] svc_high_q,
    output logic [15:0] vec_req_low,
    output logic [7:0] vec_req_high,
    output logic os_irq,
    output logic log_irq,
    output logic buserr_irq,
    output logic [15:0] ack_low,
    output logic [15:0] ack_high
);
    logic [31:0] req_q = 32'h0;
    logic [15:0] svc_low_prev, svc_high_prev;
    assign vec_req_low = req_q[15:0];
    assign vec_req_high = req_q[23:16];
    assign buserr_irq = req_q[24];
    assign log_irq = req_q[25];
    assign os_irq = req_q[26];
    // takes a vector on the rise of its service line: the service line only
    // drops two edges after the ack, so a level take would ack three times
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_low <= 16'h0;
            ack_high <= 16'h0;
            svc_low_prev <= 16'h0;
            svc_high_prev <= 16'h0;
        end else begin
            ack_low <= ack_en ? svc_low_q & ~svc_low_prev : 16'h0;
            ack_high <= ack_en ? svc_high_q & ~svc_high_prev : 16'h0;
            svc_low_prev <= svc_low_q;
            svc_high_prev <= svc_high_q;
        end
    end
    task automatic raise(input int b);
        @(posedge sys_clk);
        req_q <= 32'h1 << b;
        @(posedge sys_clk);
        req_q <= 32'h0;
    endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
/* self-checking bench: register bus, enables, service, interrupt line.
   assumes: mier_src plays the far side, mier_chk is bound to the dut. */
`timescale 1ns/1ps
`default_nettype none
`include "mier_consts.vh"
module tb_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, sw_reset = 1'b0, ack_en = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [15:0] svc_low_q, svc_high_q, vec_req_low, ack_low, ack_high;
    logic [15:0] lf = 16'h005a;
    logic [7:0] vec_req_high;
    logic global_irq_mask_q, irq_q, os_irq, log_irq, buserr_irq;
    logic [11:0] a;
    logic [31:0] d;
    int n_mismatch = 0, samples_checked = 0, i, b;
    int tbl[7] = '{2, 15, 16, 23, 24, 25, 26};
    mier_top dut_u (.*);
    mier_src src_u (.*);
    initial forever #12.5 sys_clk = ~sys_clk;
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [31:0] en_exp(input logic [11:0] ad, input logic [31:0] dv);
        return {16'h0, dv[15:0] & (ad == `MIER_OFF_EN_LOW ? `MIER_EN_LOW_WMASK : `MIER_EN_HIGH_WMASK)};
    endfunction
    task chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task wr(input logic [11:0] ad, input logic [31:0] dv);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= dv;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge sys_clk);
            aw |= s_axi_awvalid && s_axi_awready;
            w |= s_axi_wvalid && s_axi_wready;
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [11:0] ad);
        @(posedge sys_clk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        rd_v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task hw_reset;
        rst_n <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(`MIER_OFF_EN_LOW);
        chk(rd_v, 32'h0);
        rd(`MIER_OFF_EN_HIGH);
        chk(rd_v, 32'h0);
    endtask
    task end_sim;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_mismatch++;
        end_sim();
    end
    initial begin
        hw_reset();
        rd(`MIER_OFF_CTRL);
        chk(rd_v, 32'h1);
        // corners first (all ones, all zeros), then random patterns
        for (i = 0; i < 12; i++) begin
            lf = nx(lf);
            a = i[0] ? `MIER_OFF_EN_HIGH : `MIER_OFF_EN_LOW;
            d = i < 2 ? 32'hffffffff : i < 4 ? 32'h0 : {lf, lf};
            wr(a, d);
            rd(a);
            chk(rd_v, en_exp(a, d));
        end
        wr(`MIER_OFF_EN_LOW, 32'hffff);
        wr(`MIER_OFF_EN_HIGH, 32'hffff);
        @(posedge sys_clk);
        sw_reset <= 1'b1;
        @(posedge sys_clk);
        sw_reset <= 1'b0;
        rd(`MIER_OFF_EN_LOW);
        chk(rd_v, 32'hfffc);
        rd(`MIER_OFF_EN_HIGH);
        chk(rd_v, 32'h07ff);
        // masks are set, so unmasking globally comes last
        wr(`MIER_OFF_CTRL, 32'h0);
        for (i = 0; i < 12; i++) begin
            lf = nx(lf);
            b = i < 7 ? tbl[i] : 2 + lf % 25;
            src_u.raise(b);
            @(posedge sys_clk);
            @(negedge sys_clk);
            chk({svc_high_q, svc_low_q}, 32'h1 << b);
            // ack, clear and service drop take three edges; look on settled values
            repeat (3) @(negedge sys_clk);
            chk({svc_high_q, svc_low_q}, 32'h0);
        end
        wr(`MIER_OFF_EN_LOW, 32'h0);
        src_u.raise(5);
        repeat (3) @(negedge sys_clk);
        chk(svc_low_q, 16'h0);
        rd(`MIER_OFF_PEND_LOW);
        chk(rd_v, 32'h20);
        wr(`MIER_OFF_CTRL, 32'h1);
        wr(`MIER_OFF_EN_LOW, 32'h20);
        repeat (3) @(negedge sys_clk);
        chk(svc_low_q, 16'h0);
        // status is sticky from the service loop: clear it so the line must rise anew
        wr(`MIER_OFF_IRQ_STAT, 32'h3);
        wr(`MIER_OFF_IRQ_MASK, 32'h1);
        repeat (3) @(negedge sys_clk);
        chk(irq_q, 1'b0);
        wr(`MIER_OFF_CTRL, 32'h0);
        src_u.raise(3);
        repeat (5) @(negedge sys_clk);
        chk(irq_q, 1'b1);
        wr(`MIER_OFF_IRQ_STAT, 32'h3);
        wr(`MIER_OFF_IRQ_MASK, 32'h0);
        src_u.raise(4);
        repeat (5) @(negedge sys_clk);
        chk(irq_q, 1'b0);
        rd(`MIER_OFF_IRQ_STAT);
        chk(rd_v[0], 1'b1);
        // vectors 3 and 4 wait unenabled; write-one clears only vector 3
        rd(`MIER_OFF_PEND_LOW);
        chk(rd_v, 32'h18);
        wr(`MIER_OFF_PEND_LOW, 32'h08);
        rd(`MIER_OFF_PEND_LOW);
        chk(rd_v, 32'h10);
        rd(12'h100);
        chk(rs, 2'h2);
        chk(rd_v, 32'h0);
        wr(12'h100, 32'hffff);
        chk(rs, 2'h2);
        hw_reset();
        end_sim();
    end
endmodule
`default_nettype wire
